// ---- common/xas_pkg.sv ----
// Constants, records and states shared by the external-data steering block
package xas_pkg;

  // ==========================================================================
  // Window decode
  localparam logic [15:0] WIN_BASE     = 16'hF700;
  localparam logic [7:0]  WIN_PAGE     = 8'hF7;
  localparam logic [7:0]  CAN_PAGE     = 8'hF7;
  localparam int          RAM_BYTES    = 2048;
  localparam int          RAM_AW       = 11;
  localparam int          PTR_NUM      = 8;
  localparam int          SEL_W        = 3;

  // ==========================================================================
  // Special function register offsets
  localparam logic [7:0]  LO_PORT_OFS  = 8'h80;
  localparam logic [7:0]  PTR_LO_OFS   = 8'h82;
  localparam logic [7:0]  PTR_HI_OFS   = 8'h83;
  localparam logic [7:0]  PAGE_OFS     = 8'h91;
  localparam logic [7:0]  PSEL_OFS     = 8'h92;
  localparam logic [7:0]  HI_PORT_OFS  = 8'hA0;
  localparam logic [7:0]  SYSCTL_OFS   = 8'hB1;

  // ==========================================================================
  // Field positions and reset values
  localparam int          DIS_BIT      = 0;
  localparam int          VIS_BIT      = 1;
  localparam logic        DIS_RST      = 1'b1;
  localparam logic        VIS_RST      = 1'b0;
  localparam logic [7:0]  PORT_RST     = 8'hFF;
  localparam logic [7:0]  PAGE_RST     = 8'h00;
  localparam logic [SEL_W-1:0] PSEL_RST = 3'h0;
  localparam logic [15:0] PTR_RST      = 16'h0000;
  localparam logic [7:0]  SFR_NONE     = 8'h00;

  // ==========================================================================
  // Strobe timing
  localparam int          CLK_MHZ      = 40;
  localparam int          STROBE_NS    = 75;
  localparam int          STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  STRB_LAST    = 2'(STROBE_CYC - 1);

  // ==========================================================================
  // Records
  typedef struct packed {
    logic       wr;
    logic       indirect;
    logic [7:0] index_addr;
    logic [7:0] wdata;
  } xas_req_type;

  typedef struct packed {
    logic        win;
    logic        can;
    logic        strobe;
    logic        lo_bus;
    logic        hi_bus;
    logic        wr;
    logic        indirect;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xas_route_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } xas_pin_type;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_DONE} xas_state_type;

endpackage

// ---- design/xas_steer.sv ----
// External-data access steering between on-chip RAM/CAN window and external bus
`timescale 1ns/1ps

// Function
// - Pointer access hits the window only for addresses F700 through FFFF.
// - Window disable bit resets to one, sending all moves to external bus.
// - Once disable bit is cleared, software cannot set it again; reset only.
// - Visibility bit ignored outside window or while window is disabled.
// - Visibility zero keeps read and write strobes idle on window hits.
// - Visibility one drives strobes and the low port during window accesses, and the high port too on pointer accesses.
// - Indirect accesses take address bits 8 to 15 from the page register.
// - Addresses below the window go external with bus ports and active strobes.
// - Disable bit set sends window-range addresses external with active strobes.
// - Setting 00, fetch pin low: pointer window hit drives data, strobes idle.
// - Setting 00, fetch pin high: pointer window hit keeps ports as I/O.
// - Setting 10: window hit uses on-chip RAM with strobes and data visible.
// - Indirect accesses keep high port as I/O; low port is the bus externally.
// - Setting 00, fetch pin low: indirect window hit drives low port, strobes idle.
// - Setting 00, fetch pin high: indirect window hit keeps both ports I/O.
// - Window RAM and CAN area use the same move requests as external memory.
// - Two kilobytes of on-chip RAM at top of data space, beside CAN area.
// - Eight 16-bit data pointers; pointer-select register picks the active one.
// - Indirect accesses show the high port latch instead of an address byte.
module xas_steer
  import xas_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // Move requests from the core
  input  wire logic          req_valid,
  input  wire xas_req_type   req,
  output      logic          busy_q,
  output      logic          ack_q,
  output      logic [7:0]    rdata_q,
  // Special function register port
  input  wire logic          sfr_wr_en,
  input  wire logic          sfr_rd_en,
  input  wire logic [7:0]    sfr_addr,
  input  wire logic [7:0]    sfr_wdata,
  output      logic [7:0]    sfr_rdata_q,
  // Pins
  input  wire logic          ext_fetch_pin,
  input  wire logic [7:0]    low_address_data_port_in,
  output      xas_pin_type   low_address_data_port_q,
  output      xas_pin_type   high_address_port_q,
  output      logic          rd_n_q,
  output      logic          wr_n_q,
  output      logic          ale_q,
  // CAN register area
  output      logic          can_stb_q,
  output      logic          can_we_q,
  output      logic [7:0]    can_addr_q,
  output      logic [7:0]    can_wdata_q,
  input  wire logic [7:0]    can_rdata
);

  // ==========================================================================
  // Reset and pin synchronisers
  logic                 rst_meta_q;
  logic                 rst_n_q;
  logic                 fetch_meta_q;
  logic                 fetch_sync_q;
  logic [7:0]           lo_meta_q;
  logic [7:0]           lo_sync_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fetch_meta_q <= 1'b0;
      fetch_sync_q <= 1'b0;
      lo_meta_q    <= PORT_RST;
      lo_sync_q    <= PORT_RST;
    end else begin
      fetch_meta_q <= ext_fetch_pin;
      fetch_sync_q <= fetch_meta_q;
      lo_meta_q    <= low_address_data_port_in;
      lo_sync_q    <= lo_meta_q;
    end
  end

  // ==========================================================================
  // Registers
  logic                 window_disable_bit_q;
  logic                 window_visibility_bit_q;
  logic [7:0]           ext_page_q;
  logic [SEL_W-1:0]     pointer_select_q;
  logic [15:0]          data_pointer_q [PTR_NUM];
  logic [7:0]           lo_latch_q;
  logic [7:0]           hi_latch_q;
  logic [7:0]           onchip_ram_q [RAM_BYTES];

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      window_disable_bit_q    <= DIS_RST;
      window_visibility_bit_q <= VIS_RST;
    end else if (sfr_wr_en && sfr_addr == SYSCTL_OFS) begin
      window_visibility_bit_q <= sfr_wdata[VIS_BIT];
      if (!sfr_wdata[DIS_BIT]) begin
        window_disable_bit_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_page_q       <= PAGE_RST;
      pointer_select_q <= PSEL_RST;
      lo_latch_q       <= PORT_RST;
      hi_latch_q       <= PORT_RST;
    end else if (sfr_wr_en) begin
      if (sfr_addr == PAGE_OFS) begin
        ext_page_q <= sfr_wdata;
      end
      if (sfr_addr == PSEL_OFS) begin
        pointer_select_q <= sfr_wdata[SEL_W-1:0];
      end
      if (sfr_addr == LO_PORT_OFS) begin
        lo_latch_q <= sfr_wdata;
      end
      if (sfr_addr == HI_PORT_OFS) begin
        hi_latch_q <= sfr_wdata;
      end
    end
  end

  // One pointer per entry; only the selected one takes byte writes
  for (genvar g = 0; g < PTR_NUM; g++) begin : g_ptr
    always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        data_pointer_q[g] <= PTR_RST;
      end else if (sfr_wr_en && pointer_select_q == SEL_W'(g)) begin
        if (sfr_addr == PTR_LO_OFS) begin
          data_pointer_q[g][7:0] <= sfr_wdata;
        end
        if (sfr_addr == PTR_HI_OFS) begin
          data_pointer_q[g][15:8] <= sfr_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sfr_rdata_q <= SFR_NONE;
    end else if (sfr_rd_en) begin
      unique case (sfr_addr)
        SYSCTL_OFS:  sfr_rdata_q <= {6'h00, window_visibility_bit_q, window_disable_bit_q};
        PAGE_OFS:    sfr_rdata_q <= ext_page_q;
        PSEL_OFS:    sfr_rdata_q <= {5'h00, pointer_select_q};
        PTR_LO_OFS:  sfr_rdata_q <= data_pointer_q[pointer_select_q][7:0];
        PTR_HI_OFS:  sfr_rdata_q <= data_pointer_q[pointer_select_q][15:8];
        LO_PORT_OFS: sfr_rdata_q <= lo_sync_q;
        HI_PORT_OFS: sfr_rdata_q <= hi_latch_q;
        default:     sfr_rdata_q <= SFR_NONE;
      endcase
    end
  end

  // ==========================================================================
  // Steering decision
  logic [15:0]          eff_addr;
  logic                 hit;
  logic                 take;
  xas_route_type        route_d;
  xas_route_type        route_q;
  xas_route_type        cur;
  xas_state_type        state_q;
  xas_state_type        state_d;
  logic [1:0]           cnt_q;
  logic [7:0]           int_rdata;

  always_comb begin
    eff_addr = req.indirect ? {ext_page_q, req.index_addr} : data_pointer_q[pointer_select_q];
    hit      = req.indirect ? (ext_page_q >= WIN_PAGE) : (eff_addr >= WIN_BASE);
    take     = (state_q == S_IDLE) && req_valid;
    route_d.win      = hit && !window_disable_bit_q;
    route_d.can      = eff_addr[15:8] == CAN_PAGE;
    // Visibility only matters on a live window hit
    route_d.strobe   = !route_d.win || window_visibility_bit_q;
    route_d.lo_bus   = !route_d.win || window_visibility_bit_q || !fetch_sync_q;
    route_d.hi_bus   = !req.indirect && route_d.lo_bus;
    route_d.wr       = req.wr;
    route_d.indirect = req.indirect;
    route_d.addr     = eff_addr;
    route_d.wdata    = req.wdata;
    cur       = (state_q == S_IDLE) ? route_d : route_q;
    int_rdata = route_q.can ? can_rdata : onchip_ram_q[route_q.addr[RAM_AW-1:0]];
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (req_valid) state_d = S_ADDR;
      S_ADDR: state_d = S_DATA;
      S_DATA: if (cnt_q == STRB_LAST) state_d = S_DONE;
      S_DONE: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
      cnt_q   <= 2'h0;
      busy_q  <= 1'b0;
      route_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == S_DATA) ? cnt_q + 2'h1 : 2'h0;
      busy_q  <= state_d != S_IDLE;
      if (take) begin
        route_q <= route_d;
      end
    end
  end

  // ==========================================================================
  // On-chip RAM and CAN area
  always_ff @(posedge mclk) begin
    if (state_q == S_ADDR && route_q.win && !route_q.can && route_q.wr) begin
      onchip_ram_q[route_q.addr[RAM_AW-1:0]] <= route_q.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      can_stb_q   <= 1'b0;
      can_we_q    <= 1'b0;
      can_addr_q  <= 8'h00;
      can_wdata_q <= 8'h00;
    end else begin
      can_stb_q <= take && route_d.win && route_d.can;
      if (take) begin
        can_we_q    <= req.wr;
        can_addr_q  <= eff_addr[7:0];
        can_wdata_q <= req.wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= state_d == S_DONE;
      if (state_q == S_DATA && state_d == S_DONE) begin
        rdata_q <= route_q.win ? int_rdata : lo_sync_q;
      end
    end
  end

  // ==========================================================================
  // Pins
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_address_data_port_q <= '{out: PORT_RST, oe_n: PORT_RST};
      high_address_port_q     <= '{out: PORT_RST, oe_n: 8'h00};
      ale_q                   <= 1'b0;
      rd_n_q                  <= 1'b1;
      wr_n_q                  <= 1'b1;
    end else begin
      // Open-drain I/O pulls low only where the latch holds zero
      low_address_data_port_q <= '{out: lo_latch_q, oe_n: lo_latch_q};
      high_address_port_q     <= '{out: hi_latch_q, oe_n: 8'h00};
      if (state_d == S_ADDR || state_d == S_DATA) begin
        if (cur.hi_bus) begin
          high_address_port_q <= '{out: cur.addr[15:8], oe_n: 8'h00};
        end
        if (cur.lo_bus && state_d == S_ADDR) begin
          low_address_data_port_q <= '{out: cur.addr[7:0], oe_n: 8'h00};
        end else if (cur.lo_bus && cur.wr) begin
          low_address_data_port_q <= '{out: cur.wdata, oe_n: 8'h00};
        end else if (cur.lo_bus && cur.win) begin
          // Internal read data shown on the bus
          low_address_data_port_q <= '{out: int_rdata, oe_n: 8'h00};
        end else if (cur.lo_bus) begin
          low_address_data_port_q <= '{out: PORT_RST, oe_n: 8'hFF};
        end
      end
      ale_q  <= state_d == S_ADDR && cur.lo_bus;
      rd_n_q <= !(state_d == S_DATA && cur.strobe && !cur.wr);
      wr_n_q <= !(state_d == S_DATA && cur.strobe && cur.wr);
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_q);

  sequence take_s;
    state_q == S_IDLE && req_valid;
  endsequence

  sequence data_s;
    (state_q == S_DATA)[*3];
  endsequence

  reset_disable_a: assert property ($rose(rst_n_q) |-> window_disable_bit_q)
    else $error("disable bit not set after reset");
  disable_sticky_a: assert property (!$rose(window_disable_bit_q))
    else $error("disable bit set again by software");
  access_timing_a: assert property (take_s |-> ##1 (state_q == S_ADDR) ##1 data_s ##1 ack_q)
    else $error("access did not complete in five cycles");
  window_decode_a: assert property (take_s ##0 !req.indirect |=>
      route_q.win == ($past(eff_addr) >= WIN_BASE && !$past(window_disable_bit_q)))
    else $error("pointer window decode wrong");
  page_decode_a: assert property (take_s ##0 req.indirect |=>
      route_q.win == ($past(ext_page_q) >= WIN_PAGE && !$past(window_disable_bit_q)))
    else $error("page window decode wrong");
  strobe_quiet_a: assert property (take_s ##0 (route_d.win && !window_visibility_bit_q) |->
      ##1 (rd_n_q && wr_n_q)[*5])
    else $error("strobe active on hidden window access");
  ext_write_a: assert property (take_s ##0 (!route_d.win && req.wr) |->
      ##2 (!wr_n_q && rd_n_q)[*3] ##1 wr_n_q)
    else $error("external write strobe wrong");
  vis_read_a: assert property (take_s ##0 (route_d.win && window_visibility_bit_q && !req.wr) |->
      ##1 ale_q ##1 (!rd_n_q && wr_n_q)[*3])
    else $error("visible read strobe wrong");
  io_hidden_a: assert property (take_s ##0 (route_d.win && !window_visibility_bit_q && fetch_sync_q) |->
      ##1 (!ale_q && rd_n_q && wr_n_q)[*4])
    else $error("bus activity on hidden fetch-high access");
  hi_latch_a: assert property ((state_q == S_DATA && route_q.indirect) |->
      high_address_port_q.out == $past(hi_latch_q))
    else $error("high port left latch on indirect access");
  pointer_write_a: assert property ((sfr_wr_en && sfr_addr == PTR_LO_OFS) |=>
      data_pointer_q[$past(pointer_select_q)][7:0] == $past(sfr_wdata))
    else $error("selected pointer not written");

endmodule

// ---- sim/xas_ext_mem.sv ----
// External data memory model on the multiplexed low/high address ports
`timescale 1ns/1ps

module xas_ext_mem
  import xas_pkg::*;
(
  // Bus pins from the block
  input  wire logic        mclk,
  input  wire logic        ale,
  input  wire xas_pin_type lo,
  input  wire xas_pin_type hi,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  // Resolved low port and bookkeeping
  output      logic [7:0]  pin,
  output      logic [15:0] addr_q,
  output      logic [7:0]  n_stb_q
);
  logic [7:0] mem [0:65535];
  logic [7:0] float_q = 8'h00;
  logic       rd_d    = 1'b1;
  logic       wr_d    = 1'b1;
  logic [7:0] drv;
  logic [7:0] stb_cnt = 8'h00;

  assign n_stb_q = stb_cnt;
  // Released bus shows a changing pattern, never the last value
  assign drv = rd_n ? float_q : mem[addr_q];
  always_comb for (int i = 0; i < 8; i++) pin[i] = lo.oe_n[i] ? drv[i] : lo.out[i];

  always @(posedge mclk) begin
    float_q <= ~pin;
    rd_d <= rd_n;
    wr_d <= wr_n;
    if (ale) addr_q <= {hi.out, lo.out};
    if (!wr_n) mem[addr_q] <= pin;
    if ((rd_d && !rd_n) || (wr_d && !wr_n)) stb_cnt <= stb_cnt + 8'h01;
  end
endmodule

// ---- sim/xas_steer_tb.sv ----
// Self-checking bench for the external-data steering block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end

module xas_steer_tb
  import xas_pkg::*;
;
  logic mclk = 1'b0, rstn = 1'b0, req_valid = 1'b0, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0, ext_fetch_pin = 1'b0;
  xas_req_type req = '0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, can_rdata = 8'h00, pin, rdata_q, sfr_rdata_q, can_addr_q, n_stb;
  logic [7:0] can_wd;
  logic busy_q, ack_q, rd_n_q, wr_n_q, ale_q, can_stb_q, lo_drv, hi_drv, can_seen, can_we, en = 1'b0;
  logic [15:0] m_addr;
  xas_pin_type low_q, high_q;
  int n_mismatch = 0, total_checks = 0;

  always #12.5 mclk = ~mclk;

  xas_steer dut_u (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req(req), .busy_q(busy_q), .ack_q(ack_q),
    .rdata_q(rdata_q), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata_q(sfr_rdata_q), .ext_fetch_pin(ext_fetch_pin), .low_address_data_port_in(pin),
    .low_address_data_port_q(low_q), .high_address_port_q(high_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q),
    .ale_q(ale_q), .can_stb_q(can_stb_q), .can_we_q(can_we), .can_addr_q(can_addr_q), .can_wdata_q(can_wd),
    .can_rdata(can_rdata));

  xas_ext_mem mem_u (.mclk(mclk), .ale(ale_q), .lo(low_q), .hi(high_q), .rd_n(rd_n_q), .wr_n(wr_n_q),
    .pin(pin), .addr_q(m_addr), .n_stb_q(n_stb));

  // CAN area answers with the inverted register address
  always @(posedge mclk) can_rdata <= ~can_addr_q;

  // Watch port use during each access
  always @(posedge mclk) if (busy_q === 1'b1) begin
    if (low_q.oe_n === 8'h00) lo_drv <= 1'b1;
    if (high_q.out !== 8'h5A) hi_drv <= 1'b1;
    if (can_stb_q === 1'b1) can_seen <= 1'b1;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_wr_en <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr_en <= 1'b0;
  endtask

  task automatic sfr_c(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    sfr_rd_en <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd_en <= 1'b0;
    @(posedge mclk);
    #1 `CHK("sfr", e, sfr_rdata_q)
  endtask

  // One move: fetch pin, indirect, wr, address, data, strobe, low bus, high bus, read data
  task automatic go(input logic f, ind, w, input logic [15:0] a, input logic [7:0] wd,
                    input logic es, el, eh, input logic [7:0] er);
    logic [7:0] s0;
    int i;
    ext_fetch_pin <= f;
    if (ind) sfr_w(PAGE_OFS, a[15:8]);
    else begin
      sfr_w(PTR_LO_OFS, a[7:0]);
      sfr_w(PTR_HI_OFS, a[15:8]);
    end
    repeat (3) @(posedge mclk);
    s0 = n_stb;
    lo_drv <= 1'b0;
    hi_drv <= 1'b0;
    can_seen <= 1'b0;
    req_valid <= 1'b1;
    req <= '{wr: w, indirect: ind, index_addr: a[7:0], wdata: wd};
    @(posedge mclk);
    req_valid <= 1'b0;
    #1 `CHK("busy", 1'b1, busy_q)
    for (i = 0; i < 12; i++) begin
      @(posedge mclk);
      #1 if (ack_q === 1'b1) break;
    end
    if (i == 12) begin
      n_mismatch++;
      close_out();
    end
    if (!w) `CHK("rdata", er, rdata_q)
    repeat (2) @(posedge mclk);
    `CHK("idle", 1'b0, busy_q)
    `CHK("strobes", {7'h00, es}, 8'(n_stb - s0))
    `CHK("low bus", el, lo_drv)
    `CHK("high bus", eh, hi_drv)
    `CHK("can", en && a[15:8] == CAN_PAGE && !es, can_seen)
    if (es) `CHK("ext addr", ind ? {8'h5A, a[7:0]} : a, m_addr)
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    sfr_c(SYSCTL_OFS, 8'h01);
    sfr_c(PAGE_OFS, PAGE_RST);
    sfr_c(PSEL_OFS, 8'h00);
    sfr_w(HI_PORT_OFS, 8'h5A);
    $display("test reset done");
    sfr_w(SYSCTL_OFS, 8'h03);
    go(0, 0, 1, 16'hF800, 8'h11, 1, 1, 1, 8'h00);
    go(0, 1, 1, 16'hF855, 8'h22, 1, 1, 0, 8'h00);
    go(0, 0, 1, 16'h0100, 8'h33, 1, 1, 1, 8'h00);
    go(0, 0, 0, 16'hF800, 8'h00, 1, 1, 1, 8'h11);
    $display("test disabled done");
    sfr_w(SYSCTL_OFS, 8'h00);
    sfr_w(SYSCTL_OFS, 8'h01);
    sfr_c(SYSCTL_OFS, 8'h00);
    en = 1'b1;
    $display("test protect done");
    go(0, 0, 1, 16'hF800, 8'hA5, 0, 1, 1, 8'h00);
    go(0, 0, 1, 16'hF6FF, 8'h66, 1, 1, 1, 8'h00);
    go(0, 1, 1, 16'hF810, 8'h5C, 0, 1, 0, 8'h00);
    go(0, 1, 1, 16'hF620, 8'h77, 1, 1, 0, 8'h00);
    go(0, 0, 1, 16'hFFFF, 8'hC3, 0, 1, 1, 8'h00);
    go(0, 0, 0, 16'hF800, 8'h00, 0, 1, 1, 8'hA5);
    go(0, 0, 0, 16'hF6FF, 8'h00, 1, 1, 1, 8'h66);
    go(0, 0, 0, 16'hFFFF, 8'h00, 0, 1, 1, 8'hC3);
    go(0, 0, 0, 16'hF712, 8'h00, 0, 1, 1, 8'hED);
    go(0, 1, 0, 16'hF734, 8'h00, 0, 1, 0, 8'hCB);
    go(0, 0, 1, 16'hF744, 8'h3C, 0, 1, 1, 8'h00);
    `CHK("can we", 1'b1, can_we)
    `CHK("can wdata", 8'h3C, can_wd)
    $display("test window done");
    go(1, 0, 0, 16'hF800, 8'h00, 0, 0, 0, 8'hA5);
    go(1, 1, 0, 16'hF810, 8'h00, 0, 0, 0, 8'h5C);
    go(1, 1, 0, 16'h1255, 8'h00, 1, 1, 0, 8'h22);
    $display("test fetch pin done");
    sfr_w(SYSCTL_OFS, 8'h02);
    go(1, 0, 1, 16'hF900, 8'h9E, 1, 1, 1, 8'h00);
    go(1, 0, 0, 16'hF900, 8'h00, 1, 1, 1, 8'h9E);
    $display("test visible done");
    for (int i = 0; i < PTR_NUM; i++) begin
      sfr_w(PSEL_OFS, 8'(i));
      sfr_w(PTR_LO_OFS, 8'(i * 16 + 1));
      sfr_w(PTR_HI_OFS, 8'(i + 48));
    end
    for (int i = 0; i < PTR_NUM; i++) begin
      sfr_w(PSEL_OFS, 8'(i));
      sfr_c(PTR_LO_OFS, 8'(i * 16 + 1));
      sfr_c(PTR_HI_OFS, 8'(i + 48));
    end
    $display("test pointers done");
    close_out();
  end
endmodule
